// [src/sdt_trigger_ctrl.sv]
/*
 * Trigger pin, output setup and register port of the small converter.
 * Assumes the stored-settings memory answers on clk_sys, the slew engine
 * reports its busy state on clk_sys, and the bus pins are open drain.
 */
// Functional notes
// R1: Disabled trigger pin does nothing at all.
// R2: 000/001 rise powers up, fall powers down.
// R3: 010 edges start margin high/low transitions.
// R4: 011 rise starts waveform, fall stops it.
// R5: 100/101/110 edges start/stop chosen alarm.
// R6: 111 edges enable/disable bus address update.
// R7: After boot act only on pin edges.
// R8: At boot end sample level, run command.
// R9: Mapped pin blocks matching software control.
// R10: Pin functions obey register-path constraints.
// R11: Host keeps trigger pin driven, never floating.
// R12: Output code is straight binary.
// R13: Resolution is 8 or 10 bits.
// R14: Load all registers from stored memory first.
// R15: Supply reference default, bit enables internal.
// R16: Internal reference gain 1.5x/2x/3x/4x select.
// R17: Supply reference forces unity gain.
// R18: Power on Hi-Z, memory may choose 10k.
// R19: Register port is a two-wire bus slave.
// R20: New code reaches output at frame end.
// R21: Busy flag during waveform, margin, alarm.
// R22: Triggered operations start 2 us after edge; power and address commands go out at once.
// R23: Two-flop sync, one command per edge.
`timescale 1ns/100ps
module sdt_trigger_ctrl #(
	parameter int RES_BITS = 10,
	parameter logic [4:0] BUS_ADDR_HI = 5'h12
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic trigger_input_pin,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic nvm_req,
	output logic [2:0] nvm_index,
	input wire logic [15:0] nvm_data,
	input wire logic nvm_ack,
	input wire logic update_busy_in,
	output sdt_pkg::sdt_analog_t analog_out,
	output sdt_pkg::sdt_cmd_t cmd_out,
	output logic addr_update_en,
	output logic boot_done
);
	import sdt_pkg::*;

	localparam int CODE_SHIFT = CODE_MAX_BITS - RES_BITS;
	localparam int TRIG_DLY_A = TRIG_DELAY_CYC;
	localparam int TRIG_DLY_B = TRIG_DELAY_CYC - 1; // Cycle after edge to line end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Boot word index to register pointer
	function automatic logic [7:0] idx_to_ptr(input logic [2:0] idx);
		case (idx)
			3'h0: idx_to_ptr = REG_SETUP;
			3'h1: idx_to_ptr = REG_MAP;
			3'h2: idx_to_ptr = REG_ACT;
			3'h3: idx_to_ptr = REG_CODE;
			3'h4: idx_to_ptr = REG_MHI;
			default: idx_to_ptr = REG_MLO;
		endcase
	endfunction

	// Pin function select and edge to command
	function automatic sdt_cmd_t pin_cmd(input logic [2:0] sel,
		input logic rise);
		sdt_cmd_t c;
		c = '0;
		case (sdt_sel_t'(sel))
			SEL_PWR_HIZ: begin
				c.power_up = rise;
				c.pdn_hiz = !rise;
			end
			SEL_PWR_10K: begin
				c.power_up = rise;
				c.pdn_10k = !rise;
			end
			SEL_MARGIN: begin
				c.margin_hi = rise;
				c.margin_lo = !rise;
			end
			SEL_WAVE: begin
				c.func_start = rise;
				c.func_stop = !rise;
			end
			SEL_ADDR: begin
				c.addr_en = rise;
				c.addr_dis = !rise;
			end
			default: begin
				c.alarm_start = rise;
				c.alarm_stop = !rise;
				c.alarm_prio = (sel == SEL_AL_HIGH) ? PRIO_HIGH :
					(sel == SEL_AL_MED) ? PRIO_MED : PRIO_LOW;
			end
		endcase
		return c;
	endfunction

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic scl_m, scl_s, scl_p; // Clock pin sync and history
	logic sda_m, sda_s, sda_p; // Data pin sync and history
	logic trig_m, trig_s, trig_p; // Trigger pin sync and history

	// Two flops per pin, then one history flop for edges
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{scl_m, scl_s, scl_p} <= 3'h7;
			{sda_m, sda_s, sda_p} <= 3'h7;
			{trig_m, trig_s, trig_p} <= 3'h0;
		end else begin
			{scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s}; // R19
			{sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
			{trig_m, trig_s, trig_p} <= {trigger_input_pin, trig_m,
				trig_s}; // R23
		end
	end

	// ****************************************************************
	// Register file and boot load
	// ****************************************************************
	logic [15:0] setup_reg, map_reg, act_reg, code_reg, mhi_reg, mlo_reg;
	logic [2:0] boot_idx_reg; // Next stored word to fetch
	logic loading_reg; // Stored memory load running
	logic boot_done_reg, boot_done_d; // Load finished, and delayed
	logic bus_wr_stb; // Word written over the bus
	logic [7:0] bus_wr_ptr; // Its register pointer
	logic [15:0] bus_wr_data; // Its value
	logic stop_det; // Frame end on the bus

	wire boot_wr = loading_reg && nvm_ack;
	wire bus_wr = bus_wr_stb && boot_done_reg; // R10
	wire wr_en = boot_wr || bus_wr;
	wire [7:0] wr_ptr = boot_wr ? idx_to_ptr(boot_idx_reg) : bus_wr_ptr;
	wire [15:0] wr_data = boot_wr ? nvm_data : bus_wr_data;
	wire boot_last = boot_wr && (boot_idx_reg == NVM_WORDS - 3'h1);

	// Fetch each stored word once after reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			boot_idx_reg <= 3'h0;
			loading_reg <= 1'b1;
			boot_done_reg <= 1'b0;
			boot_done_d <= 1'b0;
		end else begin
			boot_done_d <= boot_done_reg;
			if (boot_wr) begin
				boot_idx_reg <= boot_idx_reg + 3'h1; // R14
			end
			if (boot_last) begin
				loading_reg <= 1'b0;
				boot_done_reg <= 1'b1;
			end
		end
	end

	// Register storage, software command bits are not kept
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			setup_reg <= SETUP_RST; // R15 R18
			map_reg <= ZERO_RST;
			act_reg <= ZERO_RST; // R1
			code_reg <= ZERO_RST;
			mhi_reg <= ZERO_RST;
			mlo_reg <= ZERO_RST;
		end else if (wr_en) begin
			case (wr_ptr)
				REG_SETUP: setup_reg <= wr_data;
				REG_MAP: map_reg <= wr_data;
				REG_ACT: act_reg <= wr_data & (16'h0001 << EN_BIT);
				REG_CODE: code_reg <= wr_data; // R12
				REG_MHI: mhi_reg <= wr_data;
				REG_MLO: mlo_reg <= wr_data;
				default: ;
			endcase
		end
	end

	// Read view of the registers, unmapped pointers read zero
	function automatic logic [15:0] reg_read(input logic [7:0] ptr,
		input logic [15:0] status);
		case (ptr)
			REG_STATUS: reg_read = status;
			REG_SETUP: reg_read = setup_reg;
			REG_MAP: reg_read = map_reg;
			REG_ACT: reg_read = act_reg;
			REG_CODE: reg_read = code_reg;
			REG_MHI: reg_read = mhi_reg;
			REG_MLO: reg_read = mlo_reg;
			default: reg_read = 16'h0000;
		endcase
	endfunction

	// ****************************************************************
	// Trigger pin decode
	// ****************************************************************
	wire pin_en = act_reg[EN_BIT];
	wire [2:0] pin_sel = map_reg[SEL_LSB +: 3];
	wire boot_pulse = boot_done_reg && !boot_done_d;
	wire pin_edge = boot_done_d && (trig_s != trig_p); // R7
	wire trig_evt = boot_pulse || pin_edge; // R8
	wire trig_dir = trig_s; // High level counts as a rising edge
	wire [12:0] pin_now = (trig_evt && pin_en) ?
		pin_cmd(pin_sel, trig_dir) : 13'h0000; // R1 R2 R3 R4 R5 R6
	wire [12:0] pin_imm = pin_now & ~DELAYED_MASK;
	wire pwr_mapped = pin_en && (pin_sel == SEL_PWR_HIZ ||
		pin_sel == SEL_PWR_10K);
	wire margin_mapped = pin_en && (pin_sel == SEL_MARGIN);
	wire wave_mapped = pin_en && (pin_sel == SEL_WAVE);
	wire addr_mapped = pin_en && (pin_sel == SEL_ADDR);
	wire act_wr = bus_wr && (bus_wr_ptr == REG_ACT);

	// Software commands, blocked while the pin owns the function
	sdt_cmd_t sw_cmd;
	always_comb begin
		sw_cmd = '0;
		sw_cmd.margin_hi = act_wr && bus_wr_data[SW_MHI_BIT] &&
			!margin_mapped; // R9
		sw_cmd.margin_lo = act_wr && bus_wr_data[SW_MLO_BIT] &&
			!margin_mapped;
		sw_cmd.func_start = act_wr && bus_wr_data[SW_FGO_BIT] &&
			!wave_mapped;
		sw_cmd.func_stop = act_wr && bus_wr_data[SW_FSTOP_BIT] &&
			!wave_mapped;
	end

	// Margin, waveform and alarm edges ride the line for the start delay
	logic [12:0] dly_q [TRIG_DELAY_CYC];
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < TRIG_DELAY_CYC; i++) begin
				dly_q[i] <= 13'h0000;
			end
		end else begin
			dly_q[0] <= pin_now & DELAYED_MASK; // R22
			for (int i = 1; i < TRIG_DELAY_CYC; i++) begin
				dly_q[i] <= dly_q[i - 1];
			end
		end
	end
	wire [12:0] pin_late = dly_q[TRIG_DELAY_CYC - 1];

	logic [12:0] cmd_reg; // Command pulses to the engines
	logic [1:0] pin_pdn_reg; // Power state set by the pin
	logic addr_upd_reg; // Address update allowed by the pin
	logic [1:0] addr_lo_reg; // Address low bits in use

	// Issue commands and keep pin-owned state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_reg <= 13'h0000;
			pin_pdn_reg <= PDN_HIZ;
			addr_upd_reg <= 1'b0;
			addr_lo_reg <= 2'h0;
		end else begin
			cmd_reg <= pin_imm | pin_late | sw_cmd; // R23
			if (pin_imm[12]) begin
				pin_pdn_reg <= PDN_ON; // R2
			end else if (pin_imm[11]) begin
				pin_pdn_reg <= PDN_HIZ;
			end else if (pin_imm[10]) begin
				pin_pdn_reg <= PDN_10K;
			end
			if (pin_imm[1]) begin
				addr_upd_reg <= 1'b1; // R6
			end else if (pin_imm[0]) begin
				addr_upd_reg <= 1'b0;
			end
			if (!addr_mapped || addr_upd_reg) begin
				addr_lo_reg <= map_reg[ADDR_LSB +: 2];
			end
		end
	end

	// ****************************************************************
	// Output setup
	// ****************************************************************
	wire [9:0] code_field = code_reg[CODE_LSB +: 10];
	logic [9:0] code_out_reg; // Code presented to the converter

	// Latch the code only at a frame end or at boot
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			code_out_reg <= 10'h000;
		end else if (stop_det || boot_pulse) begin
			code_out_reg <= 10'(code_field >> CODE_SHIFT); // R20 R13
		end
	end

	wire ref_int = setup_reg[REF_BIT]; // R15
	always_comb begin
		analog_out.code = code_out_reg; // R12
		analog_out.margin_hi = mhi_reg[MARGIN_LSB +: 8];
		analog_out.margin_lo = mlo_reg[MARGIN_LSB +: 8];
		analog_out.pdn = pwr_mapped ? pin_pdn_reg :
			setup_reg[PDN_LSB +: 2]; // R9 R18
		analog_out.ref_int = ref_int;
		analog_out.gain_sel = ref_int ? setup_reg[SPAN_LSB +: 2] :
			2'h0; // R16
		analog_out.gain_unity = !ref_int; // R17
		analog_out.step = setup_reg[STEP_LSB +: 3];
		analog_out.slew = setup_reg[SLEW_LSB +: 4];
	end

	// ****************************************************************
	// Two-wire register port
	// ****************************************************************
	sdt_bus_st_t bus_st, bus_nxt; // Bus state and state after ack
	logic [3:0] bitc; // Bits in the current byte
	logic [7:0] rx_sh, tx_sh, ptr_reg, hi_byte;
	logic hi_reg; // Next data byte is the upper one
	logic sda_oe_reg; // Pull data low

	wire scl_rise = scl_s && !scl_p;
	wire scl_fall = !scl_s && scl_p;
	wire start_det = scl_s && scl_p && sda_p && !sda_s;
	assign stop_det = scl_s && scl_p && !sda_p && sda_s;
	wire [15:0] status_word = {14'h0000, loading_reg, update_busy_in}; // R21
	wire [15:0] rd_word = reg_read(ptr_reg, status_word);
	wire [7:0] tx_first = hi_reg ? rd_word[15:8] : rd_word[7:0];
	wire [7:0] tx_again = hi_reg ? rd_word[7:0] : rd_word[15:8];
	wire rx_state = (bus_st == BS_ADDR) || (bus_st == BS_PTR) ||
		(bus_st == BS_WR);
	wire addr_hit = rx_sh[7:1] == {BUS_ADDR_HI, addr_lo_reg};

	// Bit engine: sample on clock rise, drive on clock fall
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus_st <= BS_IDLE;
			bus_nxt <= BS_IDLE;
			bitc <= 4'h0;
			{rx_sh, tx_sh, ptr_reg, hi_byte} <= 32'h00000000;
			hi_reg <= 1'b1;
			sda_oe_reg <= 1'b0;
			bus_wr_stb <= 1'b0;
			bus_wr_ptr <= 8'h00;
			bus_wr_data <= 16'h0000;
		end else begin
			bus_wr_stb <= 1'b0;
			if (start_det) begin
				bus_st <= BS_ADDR; // R19
				bitc <= 4'h0;
				sda_oe_reg <= 1'b0;
			end else if (stop_det) begin
				bus_st <= BS_IDLE;
				sda_oe_reg <= 1'b0;
			end else if (scl_rise) begin
				if (rx_state) begin
					rx_sh <= {rx_sh[6:0], sda_s};
					bitc <= bitc + 4'h1;
				end else if (bus_st == BS_RD) begin
					bitc <= bitc + 4'h1;
				end else if (bus_st == BS_RACK && sda_s) begin
					bus_st <= BS_IDLE; // Master ends the read
				end
			end else if (scl_fall) begin
				if (rx_state && bitc == 4'h8) begin
					bus_st <= BS_ACK;
					bitc <= 4'h0;
					sda_oe_reg <= 1'b1;
					bus_nxt <= BS_WR;
					if (bus_st == BS_ADDR) begin
						hi_reg <= 1'b1;
						bus_nxt <= rx_sh[0] ? BS_RD : BS_PTR;
						if (!addr_hit) begin
							bus_st <= BS_IDLE; // Not ours
							sda_oe_reg <= 1'b0;
						end
					end else if (bus_st == BS_PTR) begin
						ptr_reg <= rx_sh;
						hi_reg <= 1'b1;
					end else if (hi_reg) begin
						hi_byte <= rx_sh;
						hi_reg <= 1'b0;
					end else begin
						bus_wr_stb <= 1'b1;
						bus_wr_ptr <= ptr_reg;
						bus_wr_data <= {hi_byte, rx_sh};
						hi_reg <= 1'b1;
					end
				end else if (bus_st == BS_ACK) begin
					bus_st <= bus_nxt;
					tx_sh <= tx_first;
					sda_oe_reg <= (bus_nxt == BS_RD) && !tx_first[7];
				end else if (bus_st == BS_RD) begin
					if (bitc == 4'h8) begin
						bus_st <= BS_RACK;
						sda_oe_reg <= 1'b0;
					end else begin
						tx_sh <= {tx_sh[6:0], 1'b0};
						sda_oe_reg <= !tx_sh[6];
					end
				end else if (bus_st == BS_RACK) begin
					bus_st <= BS_RD;
					bitc <= 4'h0;
					hi_reg <= !hi_reg;
					tx_sh <= tx_again;
					sda_oe_reg <= !tx_again[7];
				end
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_reg;
	assign nvm_req = loading_reg;
	assign nvm_index = boot_idx_reg;
	assign cmd_out = cmd_reg;
	assign addr_update_en = addr_upd_reg;
	assign boot_done = boot_done_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	pin_off_quiet_a: assert property (trig_evt && !pin_en |=> // R1
		cmd_reg == ($past(pin_late) | 13'($past(sw_cmd)))
		##(TRIG_DLY_B) pin_late == 13'h0000)
		else $error("disabled pin produced a command");
	power_edge_a: assert property (pin_edge && pin_en && // R2
		pin_sel == SEL_PWR_10K && !trig_s |=> cmd_out.pdn_10k ##1
		(analog_out.pdn == PDN_10K))
		else $error("10k power-down not issued on falling edge");
	margin_delay_a: assert property (pin_edge && pin_en && // R22
		pin_sel == SEL_MARGIN && trig_s |=> ##(TRIG_DLY_A) cmd_out.margin_hi)
		else $error("margin high not started after trigger delay");
	wave_stop_a: assert property (pin_edge && pin_en && // R4
		pin_sel == SEL_WAVE && !trig_s |=> ##(TRIG_DLY_A) cmd_out.func_stop)
		else $error("waveform stop missing after falling edge");
	boot_sample_a: assert property ($rose(boot_done_reg) |-> // R8
		trig_evt ##1 !boot_pulse)
		else $error("pin level not sampled once at boot end");
	no_level_a: assert property (boot_done_d && trig_s == trig_p && // R7
		!boot_pulse |-> pin_now == 13'h0000)
		else $error("command issued without a pin edge");
	sw_block_a: assert property (act_wr && margin_mapped && // R9
		$past(pin_now, TRIG_DLY_A) == 0 |=> !cmd_out.margin_hi)
		else $error("software margin ran while pin owns it");
	code_frame_a: assert property ($changed(code_out_reg) |-> // R20
		$past(stop_det) || $past(boot_pulse))
		else $error("output code changed outside a frame end");
	load_first_a: assert property (bus_wr_stb && !boot_done_reg && // R14
		!boot_wr |=>
		$stable(setup_reg) && $stable(code_reg))
		else $error("bus write accepted during boot load");
	unity_gain_a: assert property ($fell(setup_reg[REF_BIT]) |-> // R17
		analog_out.gain_unity && analog_out.gain_sel == 2'h0)
		else $error("supply reference without unity gain");

	boot_cov: cover property ($rose(boot_done_reg));
	alarm_cov: cover property (cmd_out.alarm_start);
	frame_cov: cover property (bus_wr_stb ##[1:400] stop_det);
	addr_cov: cover property ($rose(addr_upd_reg));

endmodule

// [src/sdt_pkg.sv]
/*
 * Shared constants and types for the trigger and output setup controller.
 * Assumes a 40 MHz system clock and a two-wire register port.
 */
package sdt_pkg;

	// ****************************************************************
	// Register pointers
	// ****************************************************************
	localparam logic [7:0] REG_STATUS = 8'hd0; // Busy flags, read only
	localparam logic [7:0] REG_SETUP = 8'hd1; // output_setup
	localparam logic [7:0] REG_MAP = 8'hd2; // trigger_mapping
	localparam logic [7:0] REG_ACT = 8'hd3; // action_control
	localparam logic [7:0] REG_CODE = 8'h21; // Output code word
	localparam logic [7:0] REG_MHI = 8'h25; // Margin high code
	localparam logic [7:0] REG_MLO = 8'h26; // Margin low code

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int SPAN_LSB = 0; // output_gain_select, 2 bits
	localparam int REF_BIT = 2; // Internal reference enable
	localparam int PDN_LSB = 3; // Power-down mode, 2 bits
	localparam int SLEW_LSB = 5; // Step period select, 4 bits
	localparam int STEP_LSB = 9; // Code step select, 3 bits
	localparam int SEL_LSB = 11; // trigger_pin_function_select, 3 bits
	localparam int ADDR_LSB = 14; // Bus address low bits, 2 bits
	localparam int EN_BIT = 10; // trigger_pin_enable
	localparam int SW_MHI_BIT = 0; // Software margin high, self clearing
	localparam int SW_MLO_BIT = 1; // Software margin low, self clearing
	localparam int SW_FGO_BIT = 2; // Software waveform start
	localparam int SW_FSTOP_BIT = 3; // Software waveform stop
	localparam int CODE_LSB = 2; // Output code, 10 bits
	localparam int MARGIN_LSB = 4; // Margin code, 8 bits
	localparam int CODE_MAX_BITS = 10; // Widest code resolution

	// ****************************************************************
	// Encodings and reset values
	// ****************************************************************
	localparam logic [1:0] PDN_ON = 2'h0; // Output powered
	localparam logic [1:0] PDN_10K = 2'h1; // 10 kOhm to ground
	localparam logic [1:0] PDN_HIZ = 2'h3; // High impedance
	localparam logic [1:0] PRIO_HIGH = 2'h3;
	localparam logic [1:0] PRIO_MED = 2'h2;
	localparam logic [1:0] PRIO_LOW = 2'h1;
	localparam logic [15:0] SETUP_RST = 16'h0018; // Hi-Z, supply ref
	localparam logic [15:0] ZERO_RST = 16'h0000; // Other registers
	localparam logic [2:0] NVM_WORDS = 3'h6; // Words loaded at boot

	typedef enum logic [2:0] {
		SEL_PWR_HIZ = 3'h0,
		SEL_PWR_10K = 3'h1,
		SEL_MARGIN = 3'h2,
		SEL_WAVE = 3'h3,
		SEL_AL_HIGH = 3'h4,
		SEL_AL_MED = 3'h5,
		SEL_AL_LOW = 3'h6,
		SEL_ADDR = 3'h7
	} sdt_sel_t;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ = 40;
	localparam int TRIG_DELAY_US = 2; // Edge to start of operation
	localparam int TRIG_DELAY_CYC = TRIG_DELAY_US * CLK_MHZ;
	localparam int BUS_STD_KBPS = 100;
	localparam int BUS_FAST_KBPS = 400;
	localparam int BUS_FPLUS_KBPS = 1000;
	// Shortest half bit at the fastest rate, in system clocks
	localparam int BUS_HALF_CYC = (CLK_MHZ * 1000) / (2 * BUS_FPLUS_KBPS);

	// ****************************************************************
	// Bus slave states
	// ****************************************************************
	typedef enum logic [6:0] {
		BS_IDLE = 7'h01,
		BS_ADDR = 7'h02,
		BS_ACK = 7'h04,
		BS_PTR = 7'h08,
		BS_WR = 7'h10,
		BS_RD = 7'h20,
		BS_RACK = 7'h40
	} sdt_bus_st_t;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic power_up;
		logic pdn_hiz;
		logic pdn_10k;
		logic margin_hi;
		logic margin_lo;
		logic func_start;
		logic func_stop;
		logic alarm_start;
		logic alarm_stop;
		logic [1:0] alarm_prio;
		logic addr_en;
		logic addr_dis;
	} sdt_cmd_t;

	// Commands that wait for the trigger delay
	localparam logic [12:0] DELAYED_MASK = 13'h03fc;

	typedef struct packed {
		logic [9:0] code;
		logic [7:0] margin_hi;
		logic [7:0] margin_lo;
		logic [1:0] pdn;
		logic ref_int;
		logic [1:0] gain_sel;
		logic gain_unity;
		logic [2:0] step;
		logic [3:0] slew;
	} sdt_analog_t;

endpackage

// [dv/sdt_mem_model.sv]
/* Stored-settings memory model that answers the boot load.
   Assumes words are requested and answered on clk_sys. */
`timescale 1ns/100ps
module sdt_mem_model (
	input wire logic clk_sys,
	input wire logic nvm_req,
	input wire logic [2:0] nvm_index,
	input wire logic [15:0] words [6],
	output logic [15:0] nvm_data,
	output logic nvm_ack
);
	logic slow; // Stalls every answer for one request cycle before the ack
	initial begin
		nvm_ack = 1'b0;
		nvm_data = 16'h0;
		slow = 1'b0;
	end
	// One ack pulse a word; data toggles when not valid
	always @(negedge clk_sys) begin
		nvm_ack <= 1'b0;
		nvm_data <= ~nvm_data;
		if (nvm_req && !nvm_ack) begin
			slow <= !slow;
			if (slow) begin
				nvm_ack <= 1'b1;
				nvm_data <= words[nvm_index];
			end
		end
	end
endmodule

// [dv/tb.sv]
/* Self-checking bench of the trigger and output setup controller.
   Assumes the memory model answers the boot load. */
`timescale 1ns/100ps
module tb;
	import sdt_pkg::*;
	typedef struct packed {logic [2:0] s; logic [12:0] r, f;} sdt_row_t;
	sdt_row_t rows [8] = '{{3'h0, 13'h1000, 13'h0800},
		{3'h1, 13'h1000, 13'h0400}, {3'h2, 13'h0200, 13'h0100},
		{3'h3, 13'h0080, 13'h0040}, {3'h4, 13'h002c, 13'h001c},
		{3'h5, 13'h0028, 13'h0018}, {3'h6, 13'h0024, 13'h0014},
		{3'h7, 13'h0002, 13'h0001}};
	logic clk_sys = 0, rst = 1, trig = 0, scl = 1, sda_drv = 1;
	logic busy = 0; // Engine busy level shown in status
	logic [15:0] rdw; // Word read back over the bus
	logic [15:0] words [6];
	wire sda_out, sda_oe, nvm_req, nvm_ack, addr_update_en, boot_done;
	wire [2:0] nvm_index;
	wire [15:0] nvm_data;
	sdt_analog_t analog_out;
	sdt_cmd_t cmd_out;
	wire sda = sda_drv & ~sda_oe; // Open-drain data line
	int cyc = 0, fail_count = 0, checks_done = 0, npulse, t0, tcmd;
	logic [12:0] acc;
	sdt_trigger_ctrl #(.RES_BITS(10), .BUS_ADDR_HI(5'h12))
		i_sdt_trigger_ctrl (.clk_sys(clk_sys), .rst(rst),
		.trigger_input_pin(trig), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .nvm_req(nvm_req),
		.nvm_index(nvm_index), .nvm_data(nvm_data), .nvm_ack(nvm_ack),
		.update_busy_in(busy), .analog_out(analog_out),
		.cmd_out(cmd_out), .addr_update_en(addr_update_en),
		.boot_done(boot_done));
	sdt_mem_model i_sdt_mem_model (.clk_sys(clk_sys), .nvm_req(nvm_req),
		.nvm_index(nvm_index), .words(words), .nvm_data(nvm_data),
		.nvm_ack(nvm_ack));
	always #12.5 clk_sys = ~clk_sys;
	// Gathers command pulses; cuts a hang short
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cmd_out != 13'h0) begin
			acc <= acc | cmd_out;
			npulse <= npulse + 1;
			tcmd <= cyc;
		end
		if (cyc > 20000) begin
			fail_count = fail_count + 1;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(string nm, logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Loads stored words through a reset; waits out boot commands
	task automatic boot(logic [15:0] su, mp, ac, logic lvl);
		words = '{su, mp, ac, 16'h0400, 16'h0ff0, 16'h0100};
		trig = lvl;
		rst = 1;
		tick(2);
		rst = 0;
		for (int i = 0; i < 60 && boot_done !== 1'b1; i++) tick(1);
		check("boot", boot_done, 1);
		tick(100);
		acc = 0;
	endtask
	task automatic edge_chk(logic lvl, logic [12:0] exp);
		acc = 0;
		npulse = 0;
		t0 = cyc;
		trig = lvl;
		tick(120);
		check("cmd", acc, exp);
		check("pulses", npulse, exp != 0);
		check("late", tcmd - t0 > 79, exp[9:4] != 0);
	endtask
	// Link clock stays high outside frames
	task automatic bit_io(logic b, output logic ack);
		tick(1);
		sda_drv = b;
		tick(3);
		scl = 1;
		tick(2);
		ack = !sda;
		tick(2);
		scl = 0;
	endtask
	task automatic byte_tx(logic [7:0] v, logic ok);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(v[i], a);
		bit_io(1, a);
		check("ack", a, ok);
	endtask
	// Start condition, then the address byte
	task automatic open_tx(logic [7:0] ad, logic ok);
		tick(4);
		sda_drv = 0;
		tick(4);
		scl = 0;
		byte_tx(ad, ok);
	endtask
	task automatic wr(logic [7:0] ad, pt, logic [15:0] w, logic ok);
		open_tx(ad, ok);
		byte_tx(pt, ok);
		byte_tx(w[15:8], ok);
		byte_tx(w[7:0], ok);
	endtask
	task automatic stop();
		tick(1);
		sda_drv = 0;
		tick(3);
		scl = 1;
		tick(4);
		sda_drv = 1;
		tick(4);
	endtask
	// Sets the pointer, then reads one word; host nack ends it
	task automatic rd(logic [7:0] pt, output logic [15:0] w);
		logic a;
		open_tx(8'h90, 1);
		byte_tx(pt, 1);
		stop();
		open_tx(8'h91, 1);
		for (int i = 15; i >= 0; i--) begin
			bit_io(1, a);
			w[i] = !a;
			if (i == 8) bit_io(0, a);
		end
		bit_io(1, a);
		stop();
	endtask
	initial begin
		tick(1);
		check("pdn", analog_out.pdn, PDN_HIZ);
		check("unity", analog_out.gain_unity, 1);
		for (int i = 0; i < 8; i++) begin
			boot(16'h0018, {2'h0, rows[i].s, 11'h0}, 16'h0400, 0);
			edge_chk(1, rows[i].r);
			check("addr en", addr_update_en, rows[i].s == 3'h7);
			check("on", analog_out.pdn, rows[i].s < 2 ? PDN_ON : PDN_HIZ);
			edge_chk(0, rows[i].f);
		end
		$display("function table done");
		boot(16'h0018, 16'h0000, 16'h0000, 0);
		check("code", analog_out.code, 10'h100);
		edge_chk(1, 0);
		edge_chk(0, 0);
		boot(16'h0018, 16'h0000, 16'h0400, 1);
		check("pdn", analog_out.pdn, PDN_ON);
		boot(16'h0006, 16'h0000, 16'h0000, 0);
		check("ref", analog_out.ref_int, 1);
		check("margin", {analog_out.margin_hi, analog_out.margin_lo}, 16'hff10);
		check("gain", {analog_out.gain_unity, analog_out.gain_sel}, 2);
		$display("boot and reference done");
		boot(16'h0018, 16'h1000, 16'h0000, 0);
		wr(8'h90, 8'hd3, 16'h0001, 1);
		stop();
		tick(120);
		check("sw margin", acc[9], 1);
		wr(8'h90, 8'hd3, 16'h0400, 1);
		stop();
		tick(120);
		acc = 0;
		wr(8'h90, 8'hd3, 16'h0401, 1);
		stop();
		tick(120);
		check("sw masked", acc[9], 0);
		wr(8'h90, 8'h21, 16'h0ffc, 1);
		check("code", analog_out.code, 10'h100);
		stop();
		tick(4);
		check("code", analog_out.code, 10'h3ff);
		wr(8'h92, 8'h21, 16'h0000, 0);
		stop();
		tick(4);
		check("code", analog_out.code, 10'h3ff);
		rd(8'h21, rdw);
		check("read", rdw, 16'h0ffc);
		busy = 1;
		rd(8'hd0, rdw);
		check("status", rdw, 16'h0001);
		busy = 0;
		$display("register bus done");
		test_done();
	end
endmodule
